// File: core/io_instruction_sequencer.sv
// I/O instruction sequencer with instruction FIFO, decode and pulse trains.
//
// Behaviour
// - Idle instruction only advances program counter.
// - Output load copies accumulator to output register.
// - Codes two to six advance output address.
// - Output address decoded to one channel.
// - Monitor send gives twelve shift clocks.
// - Sync pulse after twelfth monitor clock.
// - Reset pulse after final message of iteration.
// - Convert issues one start pulse, no wait.
// - Program allows 24 microseconds per conversion.
// - Conversion done advances input counter.
// - Input counter decoded to thirty-two channels.
// - Restart clears input, output, program counters.
// - Converter input: serial mode, twelve bits LSB first.
// - Converter input steps four-bit select, strobes serializer.
// - Receiver input: two enables, twelve clocks.
// - Accumulator immediate steps three-bit memory select.
// - Multiplier immediate via mux two, twelve clocks.
// - Accumulator held zero during multiplier load.
// - Scratch address from instruction data field.
// - ALU set to pass B operand.
// - Parallel mode, scratch read, accumulator capture pulse.
`timescale 1ns/10ps
`default_nettype none
`include "io_seq_regs.svh"

// ****************************************************************
// Instruction FIFO
// ****************************************************************
// Small flip-flop FIFO; a full FIFO stalls the program memory fetch.
module io_seq_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words.
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d;  // Write index.
  logic [AW-1:0] rd_ptr_q, rd_ptr_d;  // Read index.
  logic [AW:0] count_q, count_d;  // Fill level.
  logic push, pop;

  assign wr_ready_out = (32'(count_q) < DEPTH);  // Refuses only when all DEPTH slots hold words.
  assign rd_valid_out = (count_q != '0);
  assign rd_data_out = mem_q[rd_ptr_q];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  // Next-state computation for pointers, level and storage.
  always_comb
  begin
    mem_d = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (push)
    begin
      mem_d[wr_ptr_q] = wr_data_in;
      wr_ptr_d = (32'(wr_ptr_q) == DEPTH - 1) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_d = (32'(rd_ptr_q) == DEPTH - 1) ? '0 : rd_ptr_q + 1'b1;
    end
    if (push && !pop)
    begin
      count_d = count_q + 1'b1;
    end
    else if (pop && !push)
    begin
      count_d = count_q - 1'b1;
    end
  end

  // Registering only.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mem_q <= '{default: '0};
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end
endmodule

// ****************************************************************
// Sequencer top
// ****************************************************************
module io_instruction_sequencer #(
  parameter int PC_W = 10,
  parameter int OUT_CH = 5,
  parameter int IN_CH = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [11:0] instr_in,  // Word fetched from program memory.
  input wire logic instr_valid_in,
  output logic instr_ready_out,  // Back-pressure to the fetch logic.
  output logic [PC_W-1:0] pc_out,  // Program instruction counter.
  input wire logic [11:0] acc_in,  // Accumulator parallel output.
  output logic [11:0] dac_reg_out,  // D/A output register.
  output logic [OUT_CH-1:0] sh_select_out,  // Sample-and-hold one-hot select.
  output logic mon_shift_out,  // Monitor shift register clock.
  output logic ext_clk_out,  // Clock to off-engine receiver.
  output logic ext_sync_out,  // End-of-message pulse.
  output logic ext_reset_out,  // End-of-iteration pulse.
  input wire logic last_msg_in,  // Current message is the last this iteration.
  output logic adc_start_out,
  input wire logic adc_done_in,
  output logic [IN_CH-1:0] in_select_out,  // Input channel one-hot select.
  output logic acc_mode_n_out,  // Low selects serial shift-right input.
  output logic acc_parallel_n_out,  // Low selects parallel input.
  output logic acc_clk_out,
  output logic acc_clear_out,  // Holds accumulator at zero.
  output logic in_ser_strobe_out,
  output logic [3:0] in_ser_sel_out,
  output logic mux1_ser_en_out,  // Input serializer path.
  output logic mux1_rcv_en_out,  // Receiver paths, with second enable.
  output logic mux1_rcv_en2_out,
  output logic mux1_mem_en_out,
  output logic rcv_clk_out,
  output logic [2:0] mem_ser_sel_out,
  output logic mux2_mem_en_out,
  output logic mq_shift_right_out,
  output logic mq_clk_out,
  output logic [7:0] sp_addr_out,
  output logic sp_read_out,
  output logic [4:0] alu_func_out
);
  import io_seq_pkg::*;

  // Cycles a conversion needs; a program must space convert and read by this.
  localparam int ADC_CONV_CYC = `ADC_CONV_NS / `CLK_PERIOD_NS;

  logic [11:0] word;  // Head of the FIFO.
  logic word_valid, word_take;
  logic [3:0] opc;

  io_seq_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(instr_in),
    .wr_valid_in(instr_valid_in),
    .wr_ready_out(instr_ready_out),
    .rd_data_out(word),
    .rd_valid_out(word_valid),
    .rd_ready_in(word_take)
  );
  assign opc = word[`OPC_MSB:`OPC_LSB];

  seq_state_t state_q, state_d;  // Sequencer phase.
  train_t train_q, train_d;  // Active shift train.
  logic [3:0] bit_q, bit_d;  // Bit index within the train.
  logic [PC_W-1:0] pc_q, pc_d;
  logic [$clog2(OUT_CH)-1:0] oaddr_q, oaddr_d;  // Output address counter.
  logic [4:0] iaddr_q, iaddr_d;  // Input counter.
  logic [11:0] dac_q, dac_d;
  logic [3:0] strobes_q, strobes_d;  // Registered single-cycle controls.
  logic [7:0] sp_q, sp_d;
  logic [4:0] alu_q, alu_d;
  logic last_q, last_d;  // Latched final-message flag.
  logic [3:0] mon_run_q, mon_run_d;  // Length of the running monitor train, for the checks.

  // Decode and sequence. Every instruction except restart, which returns straight to ST_FETCH,
  // passes through ST_ADVANCE, so the program counter moves only after its pulses are over.
  always_comb
  begin
    state_d = state_q;
    train_d = train_q;
    bit_d = bit_q;
    pc_d = pc_q;
    oaddr_d = oaddr_q;
    iaddr_d = iaddr_q;
    dac_d = dac_q;
    strobes_d = '0;
    sp_d = sp_q;
    alu_d = alu_q;
    last_d = last_q;
    word_take = 1'b0;
    mon_run_d = (state_q == ST_SHIFT && train_q == TR_MON) ? mon_run_q + 1'b1 : 4'h0;
    if (adc_done_in)
    begin
      iaddr_d = iaddr_q + 1'b1;
    end
    case (state_q)
      ST_FETCH:
      begin
        if (word_valid)
        begin
          word_take = 1'b1;
          bit_d = '0;
          state_d = ST_ADVANCE;
          if (opc == `OPC_OUT_LOAD)
          begin
            dac_d = acc_in;
          end
          else if (opc >= `OPC_SH_FIRST && opc <= `OPC_SH_LAST)
          begin
            oaddr_d = (32'(oaddr_q) == OUT_CH - 1) ? '0 : oaddr_q + 1'b1;
          end
          else if (opc == `OPC_MONITOR)
          begin
            train_d = TR_MON;
            last_d = last_msg_in;
            state_d = ST_SHIFT;
          end
          else if (opc == `OPC_CONVERT)
          begin
            strobes_d[0] = 1'b1;
          end
          else if (opc == `OPC_RESTART)
          begin
            iaddr_d = '0;
            oaddr_d = '0;
            state_d = ST_FETCH;
            pc_d = '0;
          end
          else if (opc >= `OPC_IN_ADC && opc <= `OPC_LMI)
          begin
            train_d = (opc == `OPC_IN_ADC) ? TR_ADC : (opc == `OPC_IN_RCV) ? TR_RCV :
                      (opc == `OPC_LAI) ? TR_LAI : TR_LMI;
            state_d = ST_SHIFT;
          end
          else if (opc == `OPC_LDA)
          begin
            sp_d = word[`DATA_MSB:`DATA_LSB];
            alu_d = `ALU_PASS_B;
            state_d = ST_STROBE;
          end
        end
      end
      ST_SHIFT:
      begin
        bit_d = bit_q + 1'b1;
        if (bit_q == `LAST_BIT)
        begin
          train_d = (train_q == TR_MON) ? TR_MON : TR_NONE;
          state_d = (train_q == TR_MON) ? ST_SYNC : ST_ADVANCE;
        end
      end
      ST_SYNC:
      begin
        strobes_d[1] = 1'b1;
        strobes_d[2] = last_q;
        train_d = TR_NONE;
        state_d = ST_ADVANCE;
      end
      ST_STROBE:
      begin
        strobes_d[3] = 1'b1;
        state_d = ST_ADVANCE;
      end
      ST_ADVANCE:
      begin
        pc_d = pc_q + 1'b1;
        state_d = ST_FETCH;
      end
      default:
      begin
        state_d = ST_FETCH;
      end
    endcase
  end

  // Registering only.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_FETCH;
      train_q <= TR_NONE;
      bit_q <= '0;
      pc_q <= '0;
      oaddr_q <= '0;
      iaddr_q <= '0;
      dac_q <= '0;
      strobes_q <= '0;
      sp_q <= '0;
      alu_q <= '0;
      last_q <= 1'b0;
      mon_run_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      train_q <= train_d;
      bit_q <= bit_d;
      pc_q <= pc_d;
      oaddr_q <= oaddr_d;
      iaddr_q <= iaddr_d;
      dac_q <= dac_d;
      strobes_q <= strobes_d;
      sp_q <= sp_d;
      alu_q <= alu_d;
      last_q <= last_d;
      mon_run_q <= mon_run_d;
    end
  end

  // ****************************************************************
  // Output decode
  // ****************************************************************
  // Shift controls are combinational from the phase; the clock lines pulse
  // once per ST_SHIFT cycle, which keeps the train exactly twelve long.
  logic shifting;
  assign shifting = (state_q == ST_SHIFT);
  assign pc_out = pc_q;
  assign dac_reg_out = dac_q;
  assign sh_select_out = OUT_CH'(1) << oaddr_q;
  assign in_select_out = IN_CH'(1) << iaddr_q;
  assign mon_shift_out = shifting && train_q == TR_MON;
  assign ext_clk_out = shifting && train_q == TR_MON;
  assign ext_sync_out = strobes_q[1];
  assign ext_reset_out = strobes_q[2];
  assign adc_start_out = strobes_q[0];
  assign acc_mode_n_out = !(shifting && (train_q == TR_ADC || train_q == TR_RCV ||
                          train_q == TR_LAI));
  assign acc_clk_out = (shifting && (train_q == TR_ADC || train_q == TR_RCV ||
                       train_q == TR_LAI)) || strobes_q[3];
  assign acc_clear_out = shifting && train_q == TR_LMI;
  assign in_ser_strobe_out = shifting && train_q == TR_ADC;
  assign in_ser_sel_out = (shifting && train_q == TR_ADC) ? bit_q : 4'h0;
  assign mux1_ser_en_out = shifting && train_q == TR_ADC;
  assign mux1_rcv_en_out = shifting && train_q == TR_RCV;
  assign mux1_rcv_en2_out = shifting && train_q == TR_RCV;
  assign rcv_clk_out = shifting && train_q == TR_RCV;
  assign mux1_mem_en_out = shifting && train_q == TR_LAI;
  assign mem_ser_sel_out = (shifting && (train_q == TR_LAI || train_q == TR_LMI)) ?
                           bit_q[2:0] : 3'h0;
  assign mux2_mem_en_out = shifting && train_q == TR_LMI;
  assign mq_shift_right_out = shifting && train_q == TR_LMI;
  assign mq_clk_out = shifting && train_q == TR_LMI;
  assign acc_parallel_n_out = !(state_q == ST_STROBE || strobes_q[3]);
  assign sp_read_out = (state_q == ST_STROBE) || strobes_q[3];
  assign sp_addr_out = sp_q;
  assign alu_func_out = alu_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // The run counter replaces a long repetition: a train must stop after exactly
  // twelve clocks, and the second check catches one that never stops.
  property p_train_len;
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(mon_shift_out) |-> mon_run_q == `WORD_BITS;
  endproperty
  a_train_len: assert property (p_train_len) else $error("Monitor train not 12.");
  property p_train_cap;
    @(posedge clk_in) disable iff (!rst_n_in)
    mon_shift_out |-> mon_run_q < `WORD_BITS;
  endproperty
  a_train_cap: assert property (p_train_cap) else $error("Monitor train too long.");
  property p_sync_after;
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(mon_shift_out) |-> ##1 ext_sync_out;
  endproperty
  a_sync_after: assert property (p_sync_after) else $error("No sync after train.");

  property p_reset_with_sync;
    @(posedge clk_in) disable iff (!rst_n_in)
    ext_reset_out |-> ext_sync_out;
  endproperty
  a_reset_with_sync: assert property (p_reset_with_sync) else $error("Reset without sync.");

  property p_start_one;
    @(posedge clk_in) disable iff (!rst_n_in)
    adc_start_out |=> !adc_start_out;
  endproperty
  a_start_one: assert property (p_start_one) else $error("Start pulse too long.");

  property p_in_count;
    @(posedge clk_in) disable iff (!rst_n_in)
    (adc_done_in && !(state_q == ST_FETCH && word_valid && opc == `OPC_RESTART)) |=>
      in_select_out == ($past(in_select_out) << 1 |
      ($past(in_select_out[IN_CH-1]) ? IN_CH'(1) : '0));
  endproperty
  a_in_count: assert property (p_in_count) else $error("Input counter not advanced.");

  property p_no_pc_in_train;
    @(posedge clk_in) disable iff (!rst_n_in)
    shifting |=> $stable(pc_q);
  endproperty
  a_no_pc_in_train: assert property (p_no_pc_in_train) else $error("PC moved mid train.");

  property p_acc_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
    mq_clk_out |-> acc_clear_out && !acc_clk_out && mux2_mem_en_out;
  endproperty
  a_acc_zero: assert property (p_acc_zero) else $error("Accumulator not held zero.");

  property p_lda_pulse;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_q == ST_STROBE) |=> acc_clk_out && !acc_parallel_n_out && sp_read_out &&
      alu_func_out == `ALU_PASS_B;
  endproperty
  a_lda_pulse: assert property (p_lda_pulse) else $error("Scratch load pulse missing.");

  property p_one_hot_out;
    @(posedge clk_in) disable iff (!rst_n_in)
    $onehot(sh_select_out) && $onehot(in_select_out);
  endproperty
  a_one_hot_out: assert property (p_one_hot_out) else $error("Select not one-hot.");
endmodule
`default_nettype wire

// File: core/io_seq_pkg.sv
// Types shared by the I/O instruction sequencer.
package io_seq_pkg;
  // Sequencer phases.
  typedef enum logic [2:0] {ST_FETCH, ST_SHIFT, ST_SYNC, ST_STROBE, ST_ADVANCE} seq_state_t;
  // Shift-train destinations.
  typedef enum logic [2:0] {TR_NONE, TR_MON, TR_ADC, TR_RCV, TR_LAI, TR_LMI} train_t;
endpackage

// File: core/io_seq_regs.svh
// Constants for the I/O instruction sequencer: opcodes, field layout, counts and timing.
`ifndef IO_SEQ_REGS_SVH
`define IO_SEQ_REGS_SVH
// ****************************************************************
// Instruction word layout
// ****************************************************************
`define OPC_MSB 11
`define OPC_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
// ****************************************************************
// Opcode encodings
// ****************************************************************
`define OPC_IDLE 4'h0
`define OPC_OUT_LOAD 4'h1
`define OPC_SH_FIRST 4'h2
`define OPC_SH_LAST 4'h6
`define OPC_MONITOR 4'h7
`define OPC_CONVERT 4'h8
`define OPC_RESTART 4'h9
`define OPC_IN_ADC 4'hA
`define OPC_IN_RCV 4'hB
`define OPC_LAI 4'hC
`define OPC_LMI 4'hD
`define OPC_LDA 4'hE
// ****************************************************************
// Counts, ALU code and timing
// ****************************************************************
`define WORD_BITS 4'hC
`define LAST_BIT 4'hB
`define ALU_PASS_B 5'h0A
`define ADC_CONV_NS 24000
`define CLK_PERIOD_NS 5
`endif

// File: sim/io_seq_far_end.sv
// Far-side model: off-engine monitor receiver and A/D converter.
`timescale 1ns/10ps
`default_nettype none
module io_seq_far_end #(
  parameter int CONV_CYC = 4800
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ext_clk_in,
  input wire logic ext_sync_in,
  input wire logic ext_reset_in,
  input wire logic adc_start_in,
  output logic adc_done_out,
  output logic [7:0] msg_id_out,
  output logic [7:0] last_bits_out
);
  logic [7:0] bits_q;  // Clocks seen in the current message.
  int conv_q;  // Cycles left in the running conversion.
  // ****************************************************************
  // Receiver
  // ****************************************************************
  // A reset pulse in the sync cycle wins, so the id returns to zero.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bits_q <= 8'h00;
      msg_id_out <= 8'h00;
      last_bits_out <= 8'h00;
    end
    else
    begin
      if (ext_clk_in) bits_q <= bits_q + 8'h01;
      if (ext_sync_in)
      begin
        last_bits_out <= bits_q;
        bits_q <= 8'h00;
        msg_id_out <= msg_id_out + 8'h01;
      end
      if (ext_reset_in) msg_id_out <= 8'h00;
    end
  end
  // ****************************************************************
  // Converter
  // ****************************************************************
  // The full conversion time is kept, so a hasty program would see it late.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      conv_q <= 0;
      adc_done_out <= 1'b0;
    end
    else
    begin
      adc_done_out <= 1'b0;
      if (adc_start_in) conv_q <= CONV_CYC;
      else if (conv_q == 1)
      begin
        conv_q <= 0;
        adc_done_out <= 1'b1;
      end
      else if (conv_q != 0) conv_q <= conv_q - 1;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_io_instruction_sequencer.sv
// Self-checking testbench for the I/O instruction sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "io_seq_regs.svh"
module tb_io_instruction_sequencer;
  import io_seq_pkg::*;
  localparam int CONV_CYC = `ADC_CONV_NS / `CLK_PERIOD_NS;
  logic clk_in, rst_n_in, instr_valid_in, instr_ready_out, last_msg_in, adc_done_in;
  logic [11:0] instr_in, acc_in, dac_reg_out;
  logic [9:0] pc_out, exp_pc;
  logic [4:0] sh_select_out, alu_func_out;
  logic [31:0] in_select_out;
  logic mon_shift_out, ext_clk_out, ext_sync_out, ext_reset_out, adc_start_out;
  logic acc_mode_n_out, acc_parallel_n_out, acc_clk_out, acc_clear_out, in_ser_strobe_out;
  logic mux1_ser_en_out, mux1_rcv_en_out, mux1_rcv_en2_out, mux1_mem_en_out, rcv_clk_out;
  logic mux2_mem_en_out, mq_shift_right_out, mq_clk_out, sp_read_out;
  logic [3:0] in_ser_sel_out;
  logic [2:0] mem_ser_sel_out;
  logic [7:0] sp_addr_out, msg_id, last_bits;
  logic [9:0] pc_prev;
  int err_count, checked, n_mon, n_sync, n_rst, n_start, n_adc, n_rcv, n_mem, n_mq;
  int n_acc, n_rd, n_par, seq_bad, n, taken;
  io_instruction_sequencer #(.PC_W(10), .OUT_CH(5), .IN_CH(32), .FIFO_DEPTH(8)) u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out), .pc_out(pc_out),
    .acc_in(acc_in), .dac_reg_out(dac_reg_out), .sh_select_out(sh_select_out),
    .mon_shift_out(mon_shift_out), .ext_clk_out(ext_clk_out), .ext_sync_out(ext_sync_out),
    .ext_reset_out(ext_reset_out), .last_msg_in(last_msg_in), .adc_start_out(adc_start_out),
    .adc_done_in(adc_done_in), .in_select_out(in_select_out), .acc_mode_n_out(acc_mode_n_out),
    .acc_parallel_n_out(acc_parallel_n_out), .acc_clk_out(acc_clk_out),
    .acc_clear_out(acc_clear_out), .in_ser_strobe_out(in_ser_strobe_out),
    .in_ser_sel_out(in_ser_sel_out), .mux1_ser_en_out(mux1_ser_en_out),
    .mux1_rcv_en_out(mux1_rcv_en_out), .mux1_rcv_en2_out(mux1_rcv_en2_out),
    .mux1_mem_en_out(mux1_mem_en_out), .rcv_clk_out(rcv_clk_out),
    .mem_ser_sel_out(mem_ser_sel_out), .mux2_mem_en_out(mux2_mem_en_out),
    .mq_shift_right_out(mq_shift_right_out), .mq_clk_out(mq_clk_out),
    .sp_addr_out(sp_addr_out), .sp_read_out(sp_read_out), .alu_func_out(alu_func_out));
  io_seq_far_end #(.CONV_CYC(CONV_CYC)) u_far (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ext_clk_in(ext_clk_out),
    .ext_sync_in(ext_sync_out), .ext_reset_in(ext_reset_out), .adc_start_in(adc_start_out),
    .adc_done_out(adc_done_in), .msg_id_out(msg_id), .last_bits_out(last_bits));
  // ****************************************************************
  // Clock and activity counters
  // ****************************************************************
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Train counters count only cycles where every companion signal of the train agrees.
  // Outputs are read at the rising edge, before that edge's updates land.
  always @(posedge clk_in)
  begin
    pc_prev <= pc_out;
    if ((mon_shift_out | ext_clk_out | acc_clk_out | mq_clk_out) && pc_out !== pc_prev) seq_bad++;
    if (in_ser_strobe_out === 1'b1 && in_ser_sel_out !== 4'(n_adc)) seq_bad++;
    if (mux1_mem_en_out === 1'b1 && mem_ser_sel_out !== 3'(n_mem)) seq_bad++;
    if (mux2_mem_en_out === 1'b1 && mem_ser_sel_out !== 3'(n_mq)) seq_bad++;
    if (mon_shift_out === 1'b1 && ext_clk_out === 1'b1) n_mon++;
    if (ext_sync_out === 1'b1) n_sync++;
    if (ext_reset_out === 1'b1) n_rst++;
    if (adc_start_out === 1'b1) n_start++;
    if ((in_ser_strobe_out & mux1_ser_en_out & acc_clk_out & ~acc_mode_n_out) === 1'b1) n_adc++;
    if ((mux1_rcv_en_out & mux1_rcv_en2_out & rcv_clk_out & acc_clk_out & ~acc_mode_n_out) === 1'b1) n_rcv++;
    if ((mux1_mem_en_out & acc_clk_out & ~acc_mode_n_out) === 1'b1) n_mem++;
    if ((mux2_mem_en_out & mq_shift_right_out & mq_clk_out & acc_clear_out & ~acc_clk_out) === 1'b1) n_mq++;
    if (acc_clk_out === 1'b1) n_acc++;
    if (sp_read_out === 1'b1) n_rd++;
    if (acc_parallel_n_out === 1'b0) n_par++;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic clear();
    {n_mon, n_sync, n_rst, n_start, n_adc, n_rcv, n_mem, n_mq, n_acc, n_rd, n_par} = '0;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Waits for the program counter, then lets trailing pulses finish.
  task automatic wait_pc(input int bound);
    n = 0;
    while (pc_out !== exp_pc && n < bound)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n >= bound)
    begin
      err_count++;
      summarize();
    end
    repeat (3) @(posedge clk_in);
  endtask
  // Presents one word and holds it until the FIFO takes it.
  task automatic exec(input logic [3:0] op, input logic [7:0] dat);
    instr_in <= {op, dat};
    instr_valid_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (instr_ready_out !== 1'b1 && n < 40);
    if (instr_ready_out !== 1'b1)
    begin
      err_count++;
      summarize();
    end
    instr_valid_in <= 1'b0;
    exp_pc = (op == `OPC_RESTART) ? 10'h000 : exp_pc + 10'h001;
    wait_pc(40);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {err_count, checked, seq_bad} = '0;
    clear();
    rst_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = 12'h000;
    acc_in = 12'h000;
    last_msg_in = 1'b0;
    exp_pc = 10'h000;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("sh_sel", 32'h0000_0001, 32'(sh_select_out));
    chk("par_n", 32'h0000_0001, 32'(acc_parallel_n_out));
    exec(`OPC_IDLE, 8'hFF);
    chk("dac", 32'h0000_0000, 32'(dac_reg_out));
    chk("acc_clk", 32'h0000_0000, n_acc);
    acc_in <= 12'hA5C;
    exec(`OPC_OUT_LOAD, 8'h00);
    chk("dac", 32'h0000_0A5C, 32'(dac_reg_out));
    for (int op = 2; op <= 6; op++)
    begin
      exec(4'(op), 8'h00);
      chk("sh_sel", 32'(5'h01 << ((op - 1) % 5)), 32'(sh_select_out));
    end
    // Two plain messages, then the last one of the iteration.
    for (int k = 0; k < 3; k++)
    begin
      last_msg_in <= (k == 2);
      clear();
      exec(`OPC_MONITOR, 8'h00);
      chk("mon_clk", 32'd12, n_mon);
      chk("bits", 32'd12, 32'(last_bits));
      chk("sync", 32'd1, n_sync);
      chk("rst", (k == 2) ? 32'd1 : 32'd0, n_rst);
      chk("msg_id", (k == 2) ? 32'd0 : 32'(k + 1), 32'(msg_id));
    end
    last_msg_in <= 1'b0;
    clear();
    exec(`OPC_CONVERT, 8'h00);
    chk("start", 32'd1, n_start);
    chk("in_sel", 32'h0000_0001, in_select_out);
    n = 0;
    while (in_select_out !== 32'h0000_0002 && n < CONV_CYC + 50)
    begin
      @(posedge clk_in);
      n++;
    end
    chk("in_sel", 32'h0000_0002, in_select_out);
    chk("in_sel_wait", 32'd1, 32'(n > CONV_CYC - 10));
    clear();
    exec(`OPC_IN_ADC, 8'h00);
    chk("adc_train", 32'd12, n_adc);
    chk("adc_acc", 32'd12, n_acc);
    clear();
    exec(`OPC_IN_RCV, 8'h00);
    chk("rcv_train", 32'd12, n_rcv);
    clear();
    exec(`OPC_LAI, 8'h5A);
    chk("lai_train", 32'd12, n_mem);
    clear();
    exec(`OPC_LMI, 8'hA5);
    chk("lmi_train", 32'd12, n_mq);
    chk("lmi_acc", 32'd0, n_acc);
    clear();
    exec(`OPC_LDA, 8'h3C);
    chk("sp_addr", 32'h0000_003C, 32'(sp_addr_out));
    chk("alu", 32'(`ALU_PASS_B), 32'(alu_func_out));
    chk("lda_acc", 32'd1, n_acc);
    chk("sp_read", 32'd2, n_rd);
    chk("par", 32'd2, n_par);
    exec(`OPC_RESTART, 8'h00);
    chk("pc", 32'h0000_0000, 32'(pc_out));
    chk("sh_sel", 32'h0000_0001, 32'(sh_select_out));
    chk("in_sel", 32'h0000_0001, in_select_out);
    // A long message keeps the decoder busy while idles fill the FIFO.
    instr_in <= {`OPC_MONITOR, 8'h00};
    instr_valid_in <= 1'b1;
    @(posedge clk_in);
    instr_in <= {`OPC_IDLE, 8'h00};
    taken = 0;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk_in);
      if (instr_ready_out !== 1'b1) break;
      taken++;
    end
    // The word refused by the full FIFO stays offered until a slot frees.
    n = 0;
    while (instr_ready_out !== 1'b1 && n < 40)
    begin
      @(posedge clk_in);
      n++;
    end
    instr_valid_in <= 1'b0;
    chk("fifo_late", 32'd1, 32'(instr_ready_out));
    chk("fifo_taken", 32'd8, taken);
    exp_pc = 10'h00A;
    wait_pc(80);
    chk("pc", 32'h0000_000A, 32'(pc_out));
    chk("seq_bad", 32'd0, seq_bad);
    summarize();
  end
endmodule
`default_nettype wire
